// ==== core/cks_pkg.sv ====
// constants, types and decode helpers for the clock source select and start-up block
// assumes one system clock; source and watchdog oscillator cycles arrive as tick pulses
package cks_pkg;

    localparam logic [7:0] ADDR_CLKSEL = 8'h00;
    localparam logic [7:0] ADDR_TRIM = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam logic [3:0] SEL_EXT = 4'h0;
    localparam logic [3:0] SEL_BAD = 4'h1;
    localparam logic [3:0] SEL_RC = 4'h2;
    localparam logic [3:0] SEL_WDT = 4'h3;

    localparam logic [1:0] STUP_FAST = 2'h0;
    localparam logic [1:0] STUP_SHORT = 2'h1;
    localparam logic [1:0] STUP_LONG = 2'h2;
    localparam logic [1:0] STUP_RSVD = 2'h3;

    localparam logic [3:0] SHIP_SRC = 4'h2;
    localparam logic [1:0] SHIP_STARTUP = 2'h2;

    localparam int WAKE_CK = 6;
    localparam int RESET_CK = 14;
    localparam int WDT_SHORT = 512;
    localparam int WDT_LONG = 8192;
    localparam logic [2:0] DIV_LAST = 3'h7;

    typedef struct packed {
        logic [1:0] startup;
        logic [3:0] srcCode;
    } cks_cfg_t;

    typedef struct packed {
        cks_cfg_t cfg;
        logic div8N;
        logic rstDisN;
    } cks_fuse_t;

    typedef enum logic [7:0] {
        SRC_EXT = 8'h01,
        SRC_RC = 8'h02,
        SRC_WDT = 8'h04,
        SRC_LFXT = 8'h08,
        SRC_XT0 = 8'h10,
        SRC_XT1 = 8'h20,
        SRC_XT2 = 8'h40,
        SRC_XT3 = 8'h80
    } cks_src_t;

    typedef enum logic [2:0] {
        PIN_IO = 3'h0,
        PIN_CLKIN = 3'h1,
        PIN_XIN = 3'h2,
        PIN_XOUT = 3'h3,
        PIN_CLKOUT = 3'h4
    } cks_pin_t;

    typedef enum logic [3:0] {
        ST_RSTDLY = 4'h1,
        ST_RSTCK = 4'h2,
        ST_START = 4'h4,
        ST_RUN = 4'h8
    } cks_state_t;

    function automatic cks_src_t cks_decode(input logic [3:0] c);
        cks_src_t s;
        s = SRC_RC;
        casez (c)
            4'b0000: s = SRC_EXT;
            4'b0011: s = SRC_WDT;
            4'b01??: s = SRC_LFXT;
            4'b100?: s = SRC_XT0;
            4'b101?: s = SRC_XT1;
            4'b110?: s = SRC_XT2;
            4'b111?: s = SRC_XT3;
            default: s = SRC_RC;
        endcase
        return s;
    endfunction

    function automatic logic cks_cfg_ok(input cks_cfg_t c, input logic rstDisN);
        logic ok;
        ok = 1'b1;
        if (c.srcCode == SEL_BAD) begin
            ok = 1'b0;
        end else if ((c.srcCode == SEL_RC || c.srcCode == SEL_WDT)
                && c.startup == STUP_RSVD) begin
            ok = 1'b0;
        end else if (c.srcCode == SEL_RC && c.startup == STUP_FAST && !rstDisN) begin
            ok = 1'b0;
        end
        return ok;
    endfunction

endpackage

// ==== core/cks_clock_select_startup.sv ====
// clock source selection, start-up timing, divide by eight and RC trim register
// assumes srcTick marks one cycle of the selected source and wdtTick one of the
// watchdog oscillator, both as one-cycle pulses synchronous to mclk
//
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
module cks_clock_select_startup #(
    parameter int ShortTimeout = cks_pkg::WDT_SHORT,
    parameter int LongTimeout = cks_pkg::WDT_LONG
) (
    input wire logic mclk,
    input wire logic rst,
    input wire cks_pkg::cks_fuse_t fuses,
    input wire logic fusesBlank,
    input wire logic [7:0] calibrationByte,
    input wire logic wakeRequest,
    input wire logic srcTick,
    input wire logic wdtTick,
    input wire logic clockOutRequest,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output cks_pkg::cks_src_t activeSource,
    output cks_pkg::cks_pin_t portB4Func,
    output cks_pkg::cks_pin_t portB5Func,
    output logic [7:0] oscillator_calibration_register,
    output logic cpuRun,
    output logic sysClkTick
);

    cks_pkg::cks_cfg_t cfgFf;
    cks_pkg::cks_cfg_t nxt_cfg;
    cks_pkg::cks_cfg_t bootCfg;
    cks_pkg::cks_cfg_t reqCfg;
    cks_pkg::cks_src_t srcFf;
    cks_pkg::cks_src_t nxt_src;
    cks_pkg::cks_pin_t pinB4Ff;
    cks_pkg::cks_pin_t pinB5Ff;
    cks_pkg::cks_state_t stateFf;
    cks_pkg::cks_state_t nxt_state;
    logic div8Ff;
    logic bootDiv8;
    logic [7:0] oscCalFf;
    logic runFf;
    logic sysTickFf;
    logic [2:0] divCntFf;
    logic [13:0] wdtCntFf;
    logic [13:0] wdtTarget;
    logic wdtDone;
    logic [3:0] ckCntFf;
    logic wrFire;
    logic arFire;
    logic cfgWrite;
    logic cfgOk;
    logic switchGo;
    logic oscWrite;
    logic wrMapped;
    logic rdMapped;
    logic bvalidFf;
    logic [1:0] brespFf;
    logic rvalidFf;
    logic [1:0] rrespFf;
    logic [31:0] rdataFf;

    // register bus handshakes
    assign wrFire = s_axi_awvalid && s_axi_wvalid && !bvalidFf;
    assign arFire = s_axi_arvalid && !rvalidFf;
    assign s_axi_awready = wrFire;
    assign s_axi_wready = wrFire;
    assign s_axi_arready = !rvalidFf;
    assign s_axi_bvalid = bvalidFf;
    assign s_axi_bresp = brespFf;
    assign s_axi_rvalid = rvalidFf;
    assign s_axi_rresp = rrespFf;
    assign s_axi_rdata = rdataFf;

    assign wrMapped = s_axi_awaddr == cks_pkg::ADDR_CLKSEL
        || s_axi_awaddr == cks_pkg::ADDR_TRIM
        || s_axi_awaddr == cks_pkg::ADDR_STATUS;
    assign rdMapped = s_axi_araddr == cks_pkg::ADDR_CLKSEL
        || s_axi_araddr == cks_pkg::ADDR_TRIM
        || s_axi_araddr == cks_pkg::ADDR_STATUS;

    assign reqCfg = cks_pkg::cks_cfg_t'(s_axi_wdata[5:0]);
    assign cfgWrite = wrFire && s_axi_wstrb[0] && s_axi_awaddr == cks_pkg::ADDR_CLKSEL;
    assign oscWrite = wrFire && s_axi_wstrb[0] && s_axi_awaddr == cks_pkg::ADDR_TRIM;
    assign cfgOk = cks_pkg::cks_cfg_ok(reqCfg, fuses.rstDisN);
    assign switchGo = cfgWrite && cfgOk;

    // boot value: fuses, or shipped defaults when blank or unusable
    always_comb begin
        if (fusesBlank || !cks_pkg::cks_cfg_ok(fuses.cfg, fuses.rstDisN)) begin
            bootCfg = '{startup: cks_pkg::SHIP_STARTUP, srcCode: cks_pkg::SHIP_SRC};
        end else begin
            bootCfg = fuses.cfg;
        end
        bootDiv8 = fusesBlank || !fuses.div8N;
    end

    always_comb begin
        if (rst) begin
            nxt_cfg = bootCfg;
        end else if (switchGo) begin
            nxt_cfg = reqCfg;
        end else begin
            nxt_cfg = cfgFf;
        end
        nxt_src = cks_pkg::cks_decode(nxt_cfg.srcCode);
    end

    always_ff @(posedge mclk) begin
        cfgFf <= nxt_cfg;
        srcFf <= nxt_src;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            div8Ff <= bootDiv8;
        end
    end

    // pin roles follow the source being entered
    always_ff @(posedge mclk) begin
        if (nxt_src == cks_pkg::SRC_EXT) begin
            pinB4Ff <= cks_pkg::PIN_CLKIN;
        end else if (nxt_src == cks_pkg::SRC_RC || nxt_src == cks_pkg::SRC_WDT) begin
            pinB4Ff <= cks_pkg::PIN_IO;
        end else begin
            pinB4Ff <= cks_pkg::PIN_XIN;
        end
        if (nxt_src[7:3] != 5'h00) begin
            pinB5Ff <= cks_pkg::PIN_XOUT;
        end else if (clockOutRequest) begin
            pinB5Ff <= cks_pkg::PIN_CLKOUT;
        end else begin
            pinB5Ff <= cks_pkg::PIN_IO;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            oscCalFf <= calibrationByte;
        end else if (oscWrite) begin
            oscCalFf <= s_axi_wdata[7:0];
        end
    end

    // reset delay target in watchdog oscillator cycles
    always_comb begin
        case (cfgFf.startup)
            cks_pkg::STUP_FAST: wdtTarget = 14'h0000;
            cks_pkg::STUP_SHORT: wdtTarget = 14'(ShortTimeout);
            default: wdtTarget = 14'(LongTimeout);
        endcase
    end

    assign wdtDone = wdtTarget == 14'h0000
        || (wdtTick && wdtCntFf == wdtTarget - 14'h0001);

    always_comb begin
        nxt_state = stateFf;
        case (stateFf)
            cks_pkg::ST_RSTDLY: begin
                if (wdtDone) begin
                    nxt_state = cks_pkg::ST_RSTCK;
                end
            end
            cks_pkg::ST_RSTCK: begin
                if (srcTick && ckCntFf == 4'(cks_pkg::RESET_CK - 1)) begin
                    nxt_state = cks_pkg::ST_RUN;
                end
            end
            cks_pkg::ST_START: begin
                if (srcTick && ckCntFf == 4'(cks_pkg::WAKE_CK - 1)) begin
                    nxt_state = cks_pkg::ST_RUN;
                end
            end
            cks_pkg::ST_RUN: begin
                if (wakeRequest) begin
                    nxt_state = cks_pkg::ST_START;
                end
            end
            default: nxt_state = cks_pkg::ST_RSTDLY;
        endcase
        if (switchGo) begin
            nxt_state = cks_pkg::ST_START;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            stateFf <= cks_pkg::ST_RSTDLY;
            runFf <= 1'b0;
        end else begin
            stateFf <= nxt_state;
            runFf <= nxt_state == cks_pkg::ST_RUN;
        end
    end

    // counted on the watchdog oscillator whichever source is active
    always_ff @(posedge mclk) begin
        if (rst || stateFf != cks_pkg::ST_RSTDLY) begin
            wdtCntFf <= 14'h0000;
        end else if (wdtTick) begin
            wdtCntFf <= wdtCntFf + 14'h0001;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst || nxt_state != stateFf || switchGo) begin
            ckCntFf <= 4'h0;
        end else if (srcTick && stateFf != cks_pkg::ST_RUN) begin
            ckCntFf <= ckCntFf + 4'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            divCntFf <= 3'h0;
            sysTickFf <= 1'b0;
        end else begin
            if (srcTick) begin
                divCntFf <= divCntFf + 3'h1;
            end
            sysTickFf <= srcTick && (!div8Ff || divCntFf == cks_pkg::DIV_LAST);
        end
    end

    // write response: unmapped or refused select code answers SLVERR
    always_ff @(posedge mclk) begin
        if (rst) begin
            bvalidFf <= 1'b0;
            brespFf <= cks_pkg::RESP_OKAY;
        end else if (wrFire) begin
            bvalidFf <= 1'b1;
            if (!wrMapped || (cfgWrite && !cfgOk)) begin
                brespFf <= cks_pkg::RESP_SLVERR;
            end else begin
                brespFf <= cks_pkg::RESP_OKAY;
            end
        end else if (s_axi_bready) begin
            bvalidFf <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rvalidFf <= 1'b0;
            rrespFf <= cks_pkg::RESP_OKAY;
            rdataFf <= 32'h0;
        end else if (arFire) begin
            rvalidFf <= 1'b1;
            rrespFf <= rdMapped ? cks_pkg::RESP_OKAY : cks_pkg::RESP_SLVERR;
            if (s_axi_araddr == cks_pkg::ADDR_CLKSEL) begin
                rdataFf <= {26'h0, cfgFf};
            end else if (s_axi_araddr == cks_pkg::ADDR_TRIM) begin
                rdataFf <= {24'h0, oscCalFf};
            end else if (s_axi_araddr == cks_pkg::ADDR_STATUS) begin
                rdataFf <= {18'h0, stateFf, div8Ff, runFf, srcFf};
            end else begin
                rdataFf <= 32'h0;
            end
        end else if (s_axi_rready) begin
            rvalidFf <= 1'b0;
        end
    end

    assign activeSource = srcFf;
    assign portB4Func = pinB4Ff;
    assign portB5Func = pinB5Ff;
    assign oscillator_calibration_register = oscCalFf;
    assign cpuRun = runFf;
    assign sysClkTick = sysTickFf;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_ext_decode: assert property (
        cfgFf.srcCode == cks_pkg::SEL_EXT |-> srcFf == cks_pkg::SRC_EXT)
        else $error("external code not decoded");

    a_top_band: assert property (
        cfgFf.srcCode[3:1] == 3'h7 |-> srcFf == cks_pkg::SRC_XT3)
        else $error("top crystal band not decoded");

    a_xtal_pins: assert property (
        srcFf[7:3] != 5'h00 |-> portB4Func == cks_pkg::PIN_XIN
            && portB5Func == cks_pkg::PIN_XOUT)
        else $error("crystal pins not assigned");

    a_wake_hold: assert property (
        stateFf == cks_pkg::ST_RUN && wakeRequest |=> stateFf == cks_pkg::ST_START && !cpuRun)
        else $error("wake did not restart the start-up count");

    a_wake_len: assert property (
        stateFf == cks_pkg::ST_START && nxt_state == cks_pkg::ST_RUN && !switchGo
            |-> srcTick && ckCntFf == 4'(cks_pkg::WAKE_CK - 1))
        else $error("wake start-up length wrong");

    a_long_delay: assert property (
        stateFf == cks_pkg::ST_RSTDLY && nxt_state == cks_pkg::ST_RSTCK
            && cfgFf.startup == cks_pkg::STUP_LONG
            |-> wdtTick && wdtCntFf == 14'(LongTimeout - 1))
        else $error("long reset delay length wrong");

    a_fuse_copy: assert property (
        $past(rst) |-> cfgFf == $past(bootCfg))
        else $error("fuses not copied at reset");

    a_shipped_def: assert property (
        $past(rst) && $past(fusesBlank) |-> srcFf == cks_pkg::SRC_RC
            && cfgFf.startup == cks_pkg::STUP_LONG && div8Ff)
        else $error("shipped defaults not applied");

    a_div_gate: assert property (
        div8Ff && sysClkTick |-> $past(srcTick) && $past(divCntFf) == cks_pkg::DIV_LAST)
        else $error("divided tick out of place");

    a_cal_load: assert property (
        $past(rst) |-> oscillator_calibration_register == $past(calibrationByte))
        else $error("calibration not loaded");

    a_cal_write: assert property (
        oscWrite |=> oscillator_calibration_register == $past(s_axi_wdata[7:0]))
        else $error("calibration write lost");

    a_fast_guard: assert property (
        cfgWrite && reqCfg.srcCode == cks_pkg::SEL_RC && reqCfg.startup == cks_pkg::STUP_FAST
            && !fuses.rstDisN |=> $stable(cfgFf) && s_axi_bresp == cks_pkg::RESP_SLVERR)
        else $error("fast start-up accepted with reset pin disabled");

    a_bad_kept: assert property (
        cfgWrite && !cfgOk |=> $stable(cfgFf) && $stable(srcFf))
        else $error("invalid select code changed the source");

endmodule // cks_clock_select_startup

// ==== tb/cks_osc_model.sv ====
// oscillator stand-in: tick pulses of the selected source and of the watchdog oscillator
// assumes ticks are sampled on mclk rising edges; slow doubles the source period
module cks_osc_model #(
    parameter int SrcPeriod = 3,
    parameter int WdtPeriod = 7
) (
    input wire logic mclk,
    input wire logic slow,
    output logic srcTick,
    output logic wdtTick
);
    timeunit 1ns;
    timeprecision 1ps;
    int srcCnt = 0;
    int wdtCnt = 0;
    initial begin
        srcTick = 1'b0;
        wdtTick = 1'b0;
    end
    always @(posedge mclk) begin
        srcCnt <= (srcCnt >= (slow ? 2 * SrcPeriod : SrcPeriod) - 1) ? 0 : srcCnt + 1;
        srcTick <= (srcCnt == 0);
    end
    // watchdog oscillator free-runs whatever source drives the system
    always @(posedge mclk) begin
        wdtCnt <= (wdtCnt == WdtPeriod - 1) ? 0 : wdtCnt + 1;
        wdtTick <= (wdtCnt == 0);
    end
endmodule // cks_osc_model

// ==== tb/clock_source_select_startup_bench.sv ====
// self-checking bench for clock source select and start-up
// assumes short delays of 4 and 8 watchdog cycles and the oscillator model as far side
module clock_source_select_startup_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int ShortT = 4;
    localparam int LongT = 8;
    logic mclk, rst, fusesBlank, wakeRequest, clockOutRequest, slow, srcTick, wdtTick;
    logic cpuRun, sysClkTick, expSys, armed, divOn;
    logic [7:0] calibrationByte, oscillator_calibration_register, s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, seed;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    cks_pkg::cks_fuse_t fuses;
    cks_pkg::cks_src_t activeSource;
    cks_pkg::cks_pin_t portB4Func, portB5Func;
    int n_errors = 0;
    int checks = 0;
    int wdtSince, srcSince, srcTotal, needT, cur, n;

    cks_clock_select_startup #(.ShortTimeout(ShortT), .LongTimeout(LongT)) dut_u (
        .mclk(mclk), .rst(rst), .fuses(fuses), .fusesBlank(fusesBlank),
        .calibrationByte(calibrationByte), .wakeRequest(wakeRequest), .srcTick(srcTick),
        .wdtTick(wdtTick), .clockOutRequest(clockOutRequest),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .activeSource(activeSource), .portB4Func(portB4Func), .portB5Func(portB5Func),
        .oscillator_calibration_register(oscillator_calibration_register), .cpuRun(cpuRun), .sysClkTick(sysClkTick)
    );
    cks_osc_model osc_u (.mclk(mclk), .slow(slow), .srcTick(srcTick), .wdtTick(wdtTick));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    function automatic logic [31:0] exp_src(input int c);
        if (c == 0) return 32'h01;
        if (c == 3) return 32'h04;
        if (c < 4) return 32'h02;
        if (c < 8) return 32'h08;
        return 32'h10 << ((c - 8) / 2);
    endfunction

    task automatic axi_write(input logic [7:0] addr, input logic [31:0] data,
                             input logic [3:0] strb, input logic [1:0] expResp);
        logic a;
        logic w;
        a = 1'b1;
        w = 1'b1;
        @(posedge mclk);
        s_axi_awaddr <= addr;
        s_axi_wdata <= data;
        s_axi_wstrb <= strb;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (a && s_axi_awready === 1'b1) begin
                a = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready === 1'b1) begin
                w = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end while (a || w);
        while (s_axi_bvalid !== 1'b1) @(posedge mclk);
        check(32'(s_axi_bresp), 32'(expResp));
        s_axi_bready <= 1'b0;
    endtask

    task automatic read_chk(input logic [7:0] addr, input logic [31:0] expData,
                            input logic [1:0] expResp);
        @(posedge mclk);
        s_axi_araddr <= addr;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge mclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge mclk);
        check(s_axi_rdata, expData);
        check(32'(s_axi_rresp), 32'(expResp));
        s_axi_rready <= 1'b0;
    endtask

    task automatic wait_run(input int wdtNeed);
        do @(posedge mclk); while (cpuRun !== 1'b1);
        check(32'(wdtSince >= wdtNeed), 32'h1);
        check(32'(srcSince >= cks_pkg::RESET_CK), 32'h1);
    endtask

    // reference of the divided system tick and of the start-up tick counts
    always @(posedge mclk) begin
        if (rst) begin
            srcTotal <= 0;
            wdtSince <= 0;
            srcSince <= 0;
            expSys <= 1'b0;
            armed <= 1'b0;
        end else begin
            if (armed) begin
                check(32'(sysClkTick), 32'(expSys));
            end
            armed <= 1'b1;
            expSys <= srcTick && (!divOn || srcTotal % 8 == 7);
            srcTotal <= srcTotal + 32'(srcTick);
            wdtSince <= wdtSince + 32'(wdtTick);
            if (wdtSince >= needT) begin
                srcSince <= srcSince + 32'(srcTick);
            end
        end
    end

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        $display("unexpected timeout at %0t: got %h expected %h", $time, 0, 1);
        wrap_up();
    end

    initial begin
        seed = lfsr(32'h8440);
        rst = 1'b1;
        fusesBlank = 1'b1;
        fuses = 8'hff;
        divOn = 1'b1;
        needT = LongT;
        calibrationByte = seed[7:0];
        {wakeRequest, clockOutRequest, slow, s_axi_awvalid, s_axi_wvalid} = 5'h0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        wait_run(LongT);
        read_chk(cks_pkg::ADDR_CLKSEL, 32'h22, cks_pkg::RESP_OKAY);
        read_chk(cks_pkg::ADDR_STATUS, 32'h2302, cks_pkg::RESP_OKAY);
        check(32'(oscillator_calibration_register), 32'(calibrationByte));
        // wake with a slow source: six source cycles before running again
        slow <= 1'b1;
        wakeRequest <= 1'b1;
        @(posedge mclk);
        wakeRequest <= 1'b0;
        n = 0;
        do begin
            @(posedge mclk);
            check(32'(cpuRun), 32'h0);
            n += 32'(srcTick);
        end while (n < cks_pkg::WAKE_CK);
        @(posedge mclk);
        check(32'(cpuRun), 32'h1);
        slow <= 1'b0;
        cur = 2;
        for (int c = 0; c < 16; c++) begin
            seed = lfsr(seed);
            clockOutRequest <= seed[0];
            axi_write(cks_pkg::ADDR_CLKSEL, 32'(c) | 32'h10, 4'h1,
                      (c == 1) ? cks_pkg::RESP_SLVERR : cks_pkg::RESP_OKAY);
            cur = (c == 1) ? cur : c;
            repeat (2) @(posedge mclk);
            check(32'(activeSource), exp_src(cur));
            check(32'(portB4Func), (cur == 0) ? 32'h1 : (cur < 4) ? 32'h0 : 32'h2);
            check(32'(portB5Func), (cur >= 4) ? 32'h3 : seed[0] ? 32'h4 : 32'h0);
            read_chk(cks_pkg::ADDR_CLKSEL, 32'h10 | 32'(cur), cks_pkg::RESP_OKAY);
        end
        axi_write(cks_pkg::ADDR_CLKSEL, 32'h32, 4'h1, cks_pkg::RESP_SLVERR);
        axi_write(cks_pkg::ADDR_CLKSEL, 32'h12, 4'h0, cks_pkg::RESP_OKAY);
        read_chk(cks_pkg::ADDR_CLKSEL, 32'h1f, cks_pkg::RESP_OKAY);
        check(32'(activeSource), 32'h80);
        seed = lfsr(seed);
        axi_write(cks_pkg::ADDR_TRIM, {24'h0, seed[7:0]}, 4'h1, cks_pkg::RESP_OKAY);
        read_chk(cks_pkg::ADDR_TRIM, {24'h0, seed[7:0]}, cks_pkg::RESP_OKAY);
        check(32'(oscillator_calibration_register), 32'(seed[7:0]));
        read_chk(8'h0c, 32'h0, cks_pkg::RESP_SLVERR);
        axi_write(cks_pkg::ADDR_STATUS, 32'h0, 4'hf, cks_pkg::RESP_OKAY);
        // second reset from programmed fuses: external clock, short delay, no divide
        @(posedge mclk);
        rst <= 1'b1;
        fusesBlank <= 1'b0;
        fuses <= 8'h42;
        divOn <= 1'b0;
        needT <= ShortT;
        calibrationByte <= seed[15:8];
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        wait_run(ShortT);
        read_chk(cks_pkg::ADDR_CLKSEL, 32'h10, cks_pkg::RESP_OKAY);
        check(32'(activeSource), 32'h01);
        check(32'(oscillator_calibration_register), 32'(seed[15:8]));
        axi_write(cks_pkg::ADDR_CLKSEL, 32'h02, 4'h1, cks_pkg::RESP_SLVERR);
        fuses.rstDisN <= 1'b1;
        axi_write(cks_pkg::ADDR_CLKSEL, 32'h02, 4'h1, cks_pkg::RESP_OKAY);
        repeat (2) @(posedge mclk);
        check(32'(activeSource), 32'h02);
        wrap_up();
    end
endmodule // clock_source_select_startup_bench
